//--- logic/rx_packet_error_tracker.sv
`default_nettype none
module rx_packet_error_tracker (
  input  wire logic                                   clock,
  input  wire logic                                   rstn,
  input  wire logic                                   received_byte_clock,
  input  wire rx_err_pkg::header_s                    header,
  input  wire rx_err_pkg::payload_s                   payload,
  input  wire logic                                   leader_sync_lost_error,
  input  wire logic [rx_err_pkg::LANES-1:0]           lane_stop_state,
  input  wire logic                                   data_valid_in,
  output logic                                        header_double_error,
  output logic                                        header_corrected_flag,
  output logic                                        header_clean_flag,
  output logic                                        payload_checksum_error,
  output logic [rx_err_pkg::NUM_VC-1:0]               unknown_packet_type_error,
  output logic [rx_err_pkg::NUM_VC-1:0]               frame_pairing_error,
  output logic [rx_err_pkg::VC_W-1:0]                 frame_pairing_vc,
  output logic [rx_err_pkg::NUM_VC-1:0]               frame_payload_error,
  output logic                                        discarding,
  output logic                                        data_valid_out,
  output logic [rx_err_pkg::LANES-1:0]                lane_ready,
  output logic                                        byte_clock_seen
);
  // link-side inputs resampled on the system clock
  logic [rx_err_pkg::LANES-1:0] stop_sync;
  logic                         sync_lost_sync;
  logic                         bclk_sync;
  logic                         bclk_prev;
  logic                         sync_lost_prev;

  rx_sync2 #(.W(rx_err_pkg::LANES + 2)) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     ({lane_stop_state, leader_sync_lost_error, received_byte_clock}),
    .q     ({stop_sync, sync_lost_sync, bclk_sync})
  );

  // the pulse spans one byte clock, so catch its rising edge only
  wire sync_lost_evt = sync_lost_sync & ~sync_lost_prev;
  wire all_stopped   = &stop_sync;

  function automatic logic dt_known(input logic [rx_err_pkg::DT_W-1:0] dt);
    dt_known = (dt <= rx_err_pkg::DT_SYNC_LAST)
      || (dt >= rx_err_pkg::DT_GENERIC_LO && dt <= rx_err_pkg::DT_GENERIC_HI)
      || (dt >= rx_err_pkg::DT_LONG_LO && dt <= rx_err_pkg::DT_LONG_HI);
  endfunction

  function automatic logic [rx_err_pkg::NUM_VC-1:0] vc_hot(
    input logic [rx_err_pkg::VC_W-1:0] vc
  );
    vc_hot = '0;
    vc_hot[vc] = 1'b1;
  endfunction

  // header classification from the syndrome
  wire hdr_zero    = header.syndrome == '0;
  wire hdr_dbl     = header.valid & ~hdr_zero & ~header.one_bit;
  wire hdr_cor     = header.valid & ~hdr_zero & header.one_bit;
  wire hdr_cln     = header.valid & hdr_zero;
  wire crc_bad     = payload.valid & (payload.received != payload.computed);

  // while discarding no headers or checksum errors reach the channel machines; link loss still does
  wire hdr_usable  = (hdr_cln | hdr_cor) & ~discarding;
  wire is_start    = hdr_usable & (header.dt == rx_err_pkg::DT_FRAME_START);
  wire is_end      = hdr_usable & (header.dt == rx_err_pkg::DT_FRAME_END);
  wire id_unknown  = hdr_usable & ~dt_known(header.dt);

  wire [rx_err_pkg::NUM_VC-1:0] hdr_sel = vc_hot(header.vc);
  wire [rx_err_pkg::NUM_VC-1:0] pay_sel = vc_hot(payload.vc);

  wire next_discarding = (hdr_dbl | sync_lost_evt) ? 1'b1 :
                         (all_stopped ? 1'b0 : discarding);

  wire [rx_err_pkg::NUM_VC-1:0] pair_raw;
  wire [rx_err_pkg::NUM_VC-1:0] data_raw;
  wire [rx_err_pkg::NUM_VC-1:0] id_raw;

  // one protocol tracker per virtual channel
  genvar g;
  generate
    for (g = 0; g < rx_err_pkg::NUM_VC; g++)
    begin : g_vc
      rx_vc_tracker u_trk (
        .clock              (clock),
        .rstn               (rstn),
        .frame_start_packet (is_start & hdr_sel[g]),
        .frame_end_packet   (is_end & hdr_sel[g]),
        .data_bad           (crc_bad & ~discarding & pay_sel[g]),
        .id_bad             (id_unknown & hdr_sel[g]),
        .link_lost          (sync_lost_evt),
        .pairing_error      (pair_raw[g]),
        .payload_error      (data_raw[g]),
        .id_error           (id_raw[g])
      );
    end
  endgenerate

  // lowest channel with a pairing error names the channel
  logic [rx_err_pkg::VC_W-1:0] pair_vc;
  always_comb
  begin
    pair_vc = rx_err_pkg::VC_ZERO;
    for (int i = rx_err_pkg::NUM_VC - 1; i >= 0; i--)
      if (pair_raw[i])
        pair_vc = i[rx_err_pkg::VC_W-1:0];
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      bclk_prev      <= 1'b0;
      sync_lost_prev <= 1'b0;
      discarding     <= 1'b0;
    end
    else
    begin
      bclk_prev      <= bclk_sync;
      sync_lost_prev <= sync_lost_sync;
      discarding     <= next_discarding;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      header_double_error       <= 1'b0;
      header_corrected_flag     <= 1'b0;
      header_clean_flag         <= 1'b0;
      payload_checksum_error    <= 1'b0;
      unknown_packet_type_error <= '0;
      frame_pairing_error       <= '0;
      frame_pairing_vc          <= rx_err_pkg::VC_ZERO;
      frame_payload_error       <= '0;
      data_valid_out            <= 1'b0;
      lane_ready                <= '0;
      byte_clock_seen           <= 1'b0;
    end
    else
    begin
      header_double_error       <= hdr_dbl;
      header_corrected_flag     <= hdr_cor;
      header_clean_flag         <= hdr_cln & ~discarding;
      payload_checksum_error    <= crc_bad;
      unknown_packet_type_error <= id_raw;
      frame_pairing_error       <= pair_raw;
      frame_pairing_vc          <= pair_vc;
      frame_payload_error       <= data_raw;
      data_valid_out            <= data_valid_in & ~next_discarding;
      lane_ready                <= stop_sync;
      byte_clock_seen           <= bclk_sync & ~bclk_prev;
    end
  end
endmodule
`default_nettype wire

//--- logic/rx_err_pkg.sv
`default_nettype none
package rx_err_pkg;
  localparam int VC_W     = 2;
  localparam int NUM_VC   = 4;
  localparam int LANES    = 4;
  localparam int SYND_W   = 6;
  localparam int DT_W     = 6;
  localparam int CRC_W    = 16;

  localparam logic [VC_W-1:0] VC_ZERO = 2'h0;

  // data type codes: short synchronisation, generic short and long packet ranges
  localparam logic [DT_W-1:0] DT_FRAME_START = 6'h00;
  localparam logic [DT_W-1:0] DT_FRAME_END   = 6'h01;
  localparam logic [DT_W-1:0] DT_SYNC_LAST   = 6'h07;
  localparam logic [DT_W-1:0] DT_GENERIC_LO  = 6'h08;
  localparam logic [DT_W-1:0] DT_GENERIC_HI  = 6'h0F;
  localparam logic [DT_W-1:0] DT_LONG_LO     = 6'h10;
  // last implemented long packet code; codes above it are not implemented
  localparam logic [DT_W-1:0] DT_LONG_HI     = 6'h37;

  typedef enum logic [1:0] {
    hdr_clean,
    hdr_corrected,
    hdr_double
  } hdr_class_e;

  // one decoded packet header as delivered by the header decoder
  typedef struct packed {
    logic              valid;
    logic [VC_W-1:0]   vc;
    logic [DT_W-1:0]   dt;
    logic [SYND_W-1:0] syndrome;
    logic              one_bit;
  } header_s;

  // end of payload with received and computed checksums
  typedef struct packed {
    logic             valid;
    logic [VC_W-1:0]  vc;
    logic [CRC_W-1:0] received;
    logic [CRC_W-1:0] computed;
  } payload_s;

  typedef enum logic [1:0] {
    vc_idle,
    vc_in_frame,
    vc_after_end
  } vc_state_e;
endpackage
`default_nettype wire

//--- logic/rx_sync2.sv
`default_nettype none
module rx_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

//--- logic/rx_vc_tracker.sv
`default_nettype none
module rx_vc_tracker (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic frame_start_packet,
  input  wire logic frame_end_packet,
  input  wire logic data_bad,
  input  wire logic id_bad,
  input  wire logic link_lost,
  output logic      pairing_error,
  output logic      payload_error,
  output logic      id_error
);
  rx_err_pkg::vc_state_e state;
  rx_err_pkg::vc_state_e next_state;
  logic                  dirty;
  logic                  next_pairing;
  logic                  next_dirty;

  always_comb
  begin
    next_state   = state;
    next_pairing = 1'b0;
    case (state)
      rx_err_pkg::vc_idle:
      begin
        if (frame_start_packet)
          next_state = rx_err_pkg::vc_in_frame;
        else if (frame_end_packet)
          next_pairing = 1'b1;
      end
      rx_err_pkg::vc_in_frame:
      begin
        if (frame_start_packet)
          next_pairing = 1'b1;
        else if (frame_end_packet)
          next_state = rx_err_pkg::vc_after_end;
      end
      rx_err_pkg::vc_after_end:
      begin
        if (frame_start_packet)
          next_state = rx_err_pkg::vc_in_frame;
        else if (frame_end_packet)
          next_pairing = 1'b1;
      end
      default:
        next_state = rx_err_pkg::vc_idle;
    endcase
    if (link_lost)
    begin
      next_state   = rx_err_pkg::vc_idle;
      next_pairing = 1'b1;
    end
  end

  // payload errors gathered since the previous frame end
  assign next_dirty = frame_end_packet ? 1'b0 : (dirty | data_bad);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state         <= rx_err_pkg::vc_idle;
      dirty         <= 1'b0;
      pairing_error <= 1'b0;
      payload_error <= 1'b0;
      id_error      <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      dirty         <= next_dirty;
      pairing_error <= next_pairing;
      payload_error <= frame_end_packet ? (dirty | data_bad) : payload_error | data_bad;
      id_error      <= id_bad | (id_error & ~frame_end_packet);
    end
  end
endmodule
`default_nettype wire

//--- verification/rx_pet_assertions.sv
`default_nettype none
module rx_pet_checker (
  input wire logic                          clock,
  input wire logic                          rstn,
  input wire rx_err_pkg::header_s           header,
  input wire rx_err_pkg::payload_s          payload,
  input wire logic                          leader_sync_lost_error,
  input wire logic [rx_err_pkg::LANES-1:0]  lane_stop_state,
  input wire logic                          header_double_error,
  input wire logic                          header_corrected_flag,
  input wire logic                          header_clean_flag,
  input wire logic                          payload_checksum_error,
  input wire logic [rx_err_pkg::NUM_VC-1:0] frame_pairing_error,
  input wire logic [rx_err_pkg::VC_W-1:0]   frame_pairing_vc,
  input wire logic                          discarding,
  input wire logic                          data_valid_out,
  input wire logic [rx_err_pkg::LANES-1:0]  lane_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic bad_hdr = header.valid && header.syndrome != 6'h00;
  wire logic bad_sum = payload.valid && payload.received != payload.computed;
  AST_DOUBLE: assert property (bad_hdr && !header.one_bit |=> header_double_error)
    else $error("double header flag missing");
  AST_CORRECTED: assert property (bad_hdr && header.one_bit |=>
    header_corrected_flag && !header_double_error) else $error("corrected flag wrong");
  AST_CLEAN: assert property (header.valid && header.syndrome == 6'h00 && !discarding
    ##1 !discarding |-> header_clean_flag) else $error("clean flag missing");
  AST_CHECKSUM: assert property (bad_sum && !discarding ##1 !discarding
    |-> payload_checksum_error) else $error("checksum flag missing");
  AST_DISCARD: assert property (bad_hdr && !header.one_bit && lane_stop_state != 4'hF
    |-> ##[1:2] discarding) else $error("discard not entered");
  AST_GATE: assert property (discarding [*2] |-> !data_valid_out)
    else $error("data qualified while discarding");
  AST_SYNC_LOST: assert property ($rose(leader_sync_lost_error)
    |-> ##[4:6] frame_pairing_error == 4'hF) else $error("sync loss not reported");
  AST_PAIR_VC: assert property ($onehot(frame_pairing_error)
    |-> frame_pairing_error[frame_pairing_vc]) else $error("pairing channel wrong");
  AST_READY: assert property ($changed(lane_stop_state) ##1 $stable(lane_stop_state) [*4]
    |-> lane_ready == lane_stop_state) else $error("lane ready wrong");
endmodule
bind rx_packet_error_tracker rx_pet_checker u_chk (
  .clock                  (clock),
  .rstn                   (rstn),
  .header                 (header),
  .payload                (payload),
  .leader_sync_lost_error (leader_sync_lost_error),
  .lane_stop_state        (lane_stop_state),
  .header_double_error    (header_double_error),
  .header_corrected_flag  (header_corrected_flag),
  .header_clean_flag      (header_clean_flag),
  .payload_checksum_error (payload_checksum_error),
  .frame_pairing_error    (frame_pairing_error),
  .frame_pairing_vc       (frame_pairing_vc),
  .discarding             (discarding),
  .data_valid_out         (data_valid_out),
  .lane_ready             (lane_ready)
);
`default_nettype wire

//--- verification/rx_phy_model.sv
`default_nettype none
module rx_phy_model (
  input  wire logic                         sync_req,
  input  wire logic [rx_err_pkg::LANES-1:0] stop_cmd,
  output logic                              received_byte_clock,
  output logic                              leader_sync_lost_error,
  output logic [rx_err_pkg::LANES-1:0]      lane_stop_state
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last = 1'b0;
  initial received_byte_clock = 1'b0;
  initial leader_sync_lost_error = 1'b0;
  // byte clock runs free on this link
  always #80 received_byte_clock = ~received_byte_clock;
  assign lane_stop_state = stop_cmd;
  always @(posedge received_byte_clock)
  begin
    last <= sync_req;
    leader_sync_lost_error <= sync_req && !last;
  end
endmodule
`default_nettype wire

//--- verification/rx_packet_error_tracker_bench.sv
`default_nettype none
module rx_packet_error_tracker_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clock = 1'b0;
  logic                 rstn = 1'b0;
  rx_err_pkg::header_s  header = '0;
  rx_err_pkg::payload_s payload = '0;
  logic                 data_valid_in = 1'b0;
  logic                 sync_req = 1'b0;
  logic [3:0]           stop_cmd = 4'h0;
  wire logic            bclk, lost, dbl, corr, clean, crc, disc, dvo, seen;
  wire logic [3:0]      stops, unk, pair, fpe, ready;
  wire logic [1:0]      pvc;
  int                   fail_count = 0;
  int                   samples_checked = 0;
  int                   cycles = 0;
  rx_phy_model PHY (.sync_req(sync_req), .stop_cmd(stop_cmd), .received_byte_clock(bclk),
    .leader_sync_lost_error(lost), .lane_stop_state(stops));
  rx_packet_error_tracker DUT (.clock(clock), .rstn(rstn), .received_byte_clock(bclk),
    .header(header), .payload(payload), .leader_sync_lost_error(lost),
    .lane_stop_state(stops), .data_valid_in(data_valid_in), .header_double_error(dbl),
    .header_corrected_flag(corr), .header_clean_flag(clean), .payload_checksum_error(crc),
    .unknown_packet_type_error(unk), .frame_pairing_error(pair), .frame_pairing_vc(pvc),
    .frame_payload_error(fpe), .discarding(disc), .data_valid_out(dvo),
    .lane_ready(ready), .byte_clock_seen(seen));
  always #2.5 clock = ~clock;
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic hdr(input logic [1:0] vc, input logic [5:0] dt, input logic [5:0] sy,
    input logic one);
    @(posedge clock);
    header <= '{1'b1, vc, dt, sy, one};
    @(posedge clock);
    header <= '0;
    #1;
  endtask
  task automatic fs(input logic [1:0] vc);
    hdr(vc, rx_err_pkg::DT_FRAME_START, 6'h00, 1'b0);
  endtask
  task automatic fe(input logic [1:0] vc);
    hdr(vc, rx_err_pkg::DT_FRAME_END, 6'h00, 1'b0);
  endtask
  task automatic pay(input logic [1:0] vc, input logic [15:0] rx, input logic [15:0] cm);
    @(posedge clock);
    payload <= '{1'b1, vc, rx, cm};
    @(posedge clock);
    payload <= '0;
    #1;
  endtask
  task automatic t_header;
    hdr(2'h0, 6'h12, 6'h00, 1'b0);
    chk("clean", {dbl, corr, clean}, 8'h01);
    hdr(2'h0, 6'h12, 6'h15, 1'b1);
    chk("corrected", {dbl, corr, clean}, 8'h02);
    hdr(2'h0, 6'h12, 6'h15, 1'b0);
    chk("double", {dbl, corr, clean}, 8'h04);
    @(posedge clock);
    data_valid_in <= 1'b1;
    tick;
    tick;
    chk("gated", {disc, dvo}, 8'h02);
    hdr(2'h0, 6'h12, 6'h00, 1'b0);
    chk("muted", clean, 8'h00);
    @(posedge clock);
    stop_cmd <= 4'hF;
    repeat (8) tick;
    chk("ready", ready, 8'h0F);
    chk("resume", {disc, dvo}, 8'h01);
    @(posedge clock);
    stop_cmd <= 4'h0;
    data_valid_in <= 1'b0;
    repeat (8) tick;
  endtask
  task automatic t_frames;
    fs(2'h0);
    fe(2'h0);
    tick;
    chk("paired", pair, 8'h00);
    fe(2'h1);
    tick;
    chk("lone end", {pair, pvc}, {2'h0, 4'h2, 2'h1});
    fs(2'h2);
    fs(2'h2);
    tick;
    chk("two starts", {pair, pvc}, {2'h0, 4'h4, 2'h2});
    fe(2'h2);
    fs(2'h3);
    fe(2'h3);
    fe(2'h3);
    tick;
    chk("two ends", {pair, pvc}, {2'h0, 4'h8, 2'h3});
    chk("type", unk, 8'h00);
    hdr(2'h1, 6'h3A, 6'h00, 1'b0);
    tick;
    chk("type set", unk, 8'h02);
    fs(2'h1);
    chk("type held", unk, 8'h02);
    fe(2'h1);
    tick;
    chk("type cleared", unk, 8'h00);
  endtask
  task automatic t_payload;
    fs(2'h0);
    pay(2'h0, 16'h1234, 16'h1234);
    chk("sum ok", crc, 8'h00);
    pay(2'h0, 16'h1234, 16'h1235);
    chk("sum bad", crc, 8'h01);
    tick;
    chk("frame bad", fpe, 8'h01);
    fe(2'h0);
    tick;
    chk("after end", fpe, 8'h01);
    fs(2'h0);
    fe(2'h0);
    tick;
    chk("clean end", fpe, 8'h00);
  endtask
  task automatic t_sync;
    int n;
    int hits;
    n = 0;
    hits = 0;
    @(posedge clock);
    sync_req <= 1'b1;
    repeat (320)
    begin
      tick;
      n += seen;
      if (pair === 4'hF)
        hits++;
    end
    chk("sync lost", hits, 8'h01);
    chk("byte edges", n, 8'h0A);
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    t_header;
    t_frames;
    t_payload;
    t_sync;
    give_verdict;
  end
endmodule
`default_nettype wire
